// ===== src/dds_core.sv
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
module dds_core #(
  parameter int NUM_CHAN = 1,
  parameter dds_pkg::dds_accum_t ACCUM = dds_pkg::ACC_STANDARD,
  parameter int MODULUS = dds_pkg::MODULUS_DEF,
  parameter real CLK_MHZ = dds_pkg::CLK_MHZ_DEF,
  parameter real FREQ_RES_HZ = dds_pkg::FREQ_RES_DEF,
  parameter int PHASE_W = dds_pkg::phase_w_for(CLK_MHZ, FREQ_RES_HZ),
  parameter int OUT_W = dds_pkg::OUT_W_DEF,
  parameter int TBL_AW = dds_pkg::TBL_AW_DEF,
  parameter dds_pkg::dds_noise_t NOISE = dds_pkg::NS_TRUNC,
  parameter dds_pkg::dds_sel_t SEL = dds_pkg::SEL_BOTH,
  parameter bit NEG_SIN = 1'b0,
  parameter bit NEG_COS = 1'b0,
  parameter dds_pkg::dds_form_t FORM = dds_pkg::FORM_TWOS,
  parameter bit QUAD_SYM = 1'b0,
  parameter dds_pkg::dds_lat_cfg_t LAT_CFG = dds_pkg::LAT_AUTO,
  parameter dds_pkg::dds_goal_t GOAL = dds_pkg::GOAL_SPEED,
  parameter int LATENCY = dds_pkg::LAT_MANUAL_DEF,
  parameter bit LUT_ONLY = 1'b0,
  parameter bit RUN_RST = 1'b1,
  parameter logic [dds_pkg::CHAN_MAX-1:0][PHASE_W-1:0] PER_CHANNEL_STEP =
    '{default: PHASE_W'(1) << (PHASE_W - dds_pkg::STEP_SHIFT_DEF)},
  parameter bit SHIFT_PRESENT = 1'b0,
  parameter logic [dds_pkg::CHAN_MAX-1:0][PHASE_W-1:0] PER_CHANNEL_SHIFT =
    '0,
  localparam int DATA_W = (SEL == dds_pkg::SEL_BOTH) ? 2 * OUT_W : OUT_W
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [dds_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [dds_pkg::WB_SEL_W-1:0] wb_sel_i,
  input wire logic [dds_pkg::WB_DATA_W-1:0] wb_dat_i,
  output logic [dds_pkg::WB_DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic s_phase_tvalid,
  output logic s_phase_tready,
  input wire logic [PHASE_W-1:0] s_phase_tdata,
  output logic m_data_tvalid,
  input wire logic m_data_tready,
  output logic [DATA_W-1:0] m_data_tdata,
  output logic m_phase_tvalid,
  input wire logic m_phase_tready,
  output logic [PHASE_W-1:0] m_phase_tdata
);
  import dds_pkg::*;

  localparam int CHAN_W = (NUM_CHAN > 1) ? $clog2(NUM_CHAN) : 1; // see [R1]
  localparam int TBL_DEPTH = 2 ** TBL_AW;
  localparam int FRAC_W = PHASE_W - TBL_AW;
  localparam int DITH_W = (FRAC_W < LFSR_W) ? FRAC_W : LFSR_W;
  localparam int RASTER_W = $clog2(MODULUS - 1); // see [R5]
  localparam int DELTA_W = FRAC_W + TWO_PI_W + 2;
  localparam int PROD_W = DELTA_W + OUT_W;
  localparam int PIPE_LAT = (LAT_CFG == LAT_AUTO) ?
    ((GOAL == GOAL_SPEED) ? AUTO_LAT_SPEED : AUTO_LAT_AREA) :
    ((LATENCY < 1) ? 1 : LATENCY); // see [R16]
  localparam bit RASTER = (ACCUM == ACC_RASTERIZED); // see [R4]
  localparam bit USE_SM = (FORM == FORM_SIGN_MAG) && QUAD_SYM; // see [R13]
  localparam real AMP = (2.0 ** (OUT_W - 1)) - 1.0;
  localparam logic signed [PROD_W-1:0] MAXV =
    {{(PROD_W - OUT_W + 1){1'b0}}, {(OUT_W - 1){1'b1}}};
  localparam logic [WB_DATA_W-1:0] WB_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic [OUT_W-1:0] sin;
    logic [OUT_W-1:0] cos;
    logic [PHASE_W-1:0] phase;
  } dds_stage_t;

  typedef struct packed {
    logic [NUM_CHAN-1:0][PHASE_W-1:0] acc;
    logic [CHAN_W-1:0] chan;
    logic [LFSR_W-1:0] lfsr;
    dds_stage_t [PIPE_LAT-1:0] pipe;
    logic data_done;
    logic phase_done;
    logic run;
    logic neg_sin;
    logic neg_cos;
    logic ack;
    logic [WB_DATA_W-1:0] rdata;
  } dds_state_t;

  localparam dds_state_t RST_STATE = '{run: RUN_RST, neg_sin: NEG_SIN,
    neg_cos: NEG_COS, default: '0};

  // Sine or cosine table, one full period over the table depth, or over the first MODULUS entries when rasterized
  function automatic logic [TBL_DEPTH-1:0][OUT_W-1:0] build_tbl(
    input bit cosine);
    real ang;
    real period;
    real val;
    build_tbl = '0;
    period = RASTER ? real'(MODULUS) : real'(TBL_DEPTH);
    for (int i = 0; i < TBL_DEPTH; i++) begin
      ang = TWO_PI_REAL * real'(i) / period;
      val = cosine ? $cos(ang) : $sin(ang);
      build_tbl[i] = OUT_W'(longint'(AMP * val));
    end
  endfunction

  localparam logic [TBL_DEPTH-1:0][OUT_W-1:0] SIN_TBL = build_tbl(1'b0);
  localparam logic [TBL_DEPTH-1:0][OUT_W-1:0] COS_TBL = build_tbl(1'b1);

  // Phase sum, modulo the modulus when rasterized
  function automatic logic [PHASE_W-1:0] mod_add(
    input logic [PHASE_W-1:0] a, input logic [PHASE_W-1:0] b);
    logic [PHASE_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (RASTER && s >= (PHASE_W + 1)'(MODULUS)) begin // see [R3] see [R20]
      s = s - (PHASE_W + 1)'(MODULUS);
    end
    return s[PHASE_W-1:0]; // see [R20]
  endfunction

  // Build-time step or shift, reduced into range
  function automatic logic [PHASE_W-1:0] fixed_val(
    input logic [PHASE_W-1:0] v);
    return RASTER ? PHASE_W'(v % PHASE_W'(MODULUS)) : v; // see [R17]
  endfunction

  // Clamp a corrected value to the table amplitude
  function automatic logic [OUT_W-1:0] sat(input logic signed [PROD_W-1:0] x);
    if (x > MAXV) begin
      return MAXV[OUT_W-1:0];
    end else if (x < -MAXV) begin
      return OUT_W'(-MAXV);
    end
    return x[OUT_W-1:0];
  endfunction

  // Negation then output form
  function automatic logic [OUT_W-1:0] shape(input logic [OUT_W-1:0] v,
    input logic neg);
    logic [OUT_W-1:0] r;
    logic [OUT_W-1:0] mag;
    r = neg ? OUT_W'(-v) : v; // see [R12]
    mag = OUT_W'(-r);
    // Sign bit on top, magnitude below it
    if (USE_SM && r[OUT_W-1]) begin
      r = {1'b1, mag[OUT_W-2:0]};
    end
    return r; // see [R13]
  endfunction

  dds_state_t state_ff;
  dds_state_t nxt_state;
  dds_stage_t last;
  dds_stage_t stage_in;
  logic advance;
  logic src_valid;
  logic [PHASE_W-1:0] acc_cur;
  logic [PHASE_W-1:0] step_cur;
  logic [PHASE_W-1:0] src_phase;
  logic [PHASE_W-1:0] shifted;
  logic [PHASE_W-1:0] dithered;
  logic [TBL_AW-1:0] addr;
  logic [FRAC_W-1:0] frac;
  logic signed [OUT_W-1:0] sin_raw;
  logic signed [OUT_W-1:0] cos_raw;
  logic signed [DELTA_W-1:0] frac_ext;
  logic signed [DELTA_W-1:0] tp_ext;
  logic signed [DELTA_W-1:0] delta;
  logic signed [PROD_W-1:0] delta_ext;
  logic signed [PROD_W-1:0] sin_ext;
  logic signed [PROD_W-1:0] cos_ext;
  logic signed [PROD_W-1:0] sin_fix;
  logic signed [PROD_W-1:0] cos_fix;
  logic [OUT_W-1:0] sin_sh;
  logic [OUT_W-1:0] cos_sh;
  logic [WB_DATA_W-1:0] ctrl_word;
  logic [WB_DATA_W-1:0] stat_word;

  // Source of phase: accumulator or input stream
  assign last = state_ff.pipe[PIPE_LAT-1];
  assign advance = !last.valid ||
    ((state_ff.data_done || m_data_tready) &&
     (state_ff.phase_done || m_phase_tready)); // see [R19]
  assign src_valid = LUT_ONLY ? s_phase_tvalid : state_ff.run;
  assign acc_cur = state_ff.acc[state_ff.chan];
  assign step_cur = fixed_val(PER_CHANNEL_STEP[state_ff.chan]); // see [R14]
  assign src_phase = LUT_ONLY ? s_phase_tdata : acc_cur; // see [R7]
  assign shifted = (SHIFT_PRESENT && !LUT_ONLY) ?
    mod_add(src_phase, fixed_val(PER_CHANNEL_SHIFT[state_ff.chan])) :
    src_phase; // see [R15]

  // Table address, dither and truncation
  assign dithered = (NOISE == NS_DITHER && !RASTER) ?
    shifted + PHASE_W'(state_ff.lfsr[DITH_W-1:0]) : shifted; // see [R9]
  assign addr = RASTER ? shifted[TBL_AW-1:0] :
    dithered[PHASE_W-1 -: TBL_AW]; // see [R2]
  assign frac = shifted[FRAC_W-1:0];
  assign sin_raw = SIN_TBL[addr];
  assign cos_raw = COS_TBL[addr];

  // Taylor term from the discarded phase bits
  assign frac_ext = DELTA_W'(frac);
  assign tp_ext = DELTA_W'(TWO_PI_Q);
  assign delta = frac_ext * tp_ext;
  assign delta_ext = PROD_W'(delta);
  assign sin_ext = PROD_W'(sin_raw);
  assign cos_ext = PROD_W'(cos_raw);
  always_comb begin
    sin_fix = sin_ext;
    cos_fix = cos_ext;
    if (NOISE == NS_TAYLOR && !RASTER) begin // see [R9]
      sin_fix = sin_ext + ((cos_ext * delta_ext) >>> (PHASE_W + TWO_PI_FRAC));
      cos_fix = cos_ext - ((sin_ext * delta_ext) >>> (PHASE_W + TWO_PI_FRAC));
    end
  end
  assign sin_sh = shape(sat(sin_fix), state_ff.neg_sin); // see [R10]
  assign cos_sh = shape(sat(cos_fix), state_ff.neg_cos);

  // Beat entering the pipeline
  assign stage_in.valid = src_valid;
  assign stage_in.sin = sin_sh;
  assign stage_in.cos = cos_sh;
  assign stage_in.phase = RASTER ? PHASE_W'(src_phase[RASTER_W-1:0]) :
    src_phase; // see [R5] see [R6]

  // Register words
  assign ctrl_word = WB_ZERO | (WB_DATA_W'(state_ff.run) << CTRL_RUN_BIT) |
    (WB_DATA_W'(state_ff.neg_sin) << CTRL_NEG_SIN_BIT) |
    (WB_DATA_W'(state_ff.neg_cos) << CTRL_NEG_COS_BIT);
  assign stat_word = WB_ZERO | (WB_DATA_W'(last.valid) << STAT_VALID_BIT) |
    (WB_DATA_W'(!advance) << STAT_STALL_BIT) |
    (WB_DATA_W'(STAT_CHAN_W'(state_ff.chan)) << STAT_CHAN_LSB);

  // Next state
  always_comb begin
    nxt_state = state_ff;
    if (advance) begin
      nxt_state.pipe[0] = stage_in;
      for (int i = 1; i < PIPE_LAT; i++) begin
        nxt_state.pipe[i] = state_ff.pipe[i-1];
      end
      nxt_state.data_done = 1'b0;
      nxt_state.phase_done = 1'b0;
      if (src_valid) begin
        nxt_state.lfsr = {state_ff.lfsr[LFSR_W-2:0],
          ~^(state_ff.lfsr & LFSR_TAPS)};
        if (!LUT_ONLY) begin
          nxt_state.acc[state_ff.chan] = mod_add(acc_cur, step_cur);
        end
        nxt_state.chan = (state_ff.chan == CHAN_W'(NUM_CHAN - 1)) ?
          '0 : state_ff.chan + 1'b1; // see [R1]
      end
    end else begin
      nxt_state.data_done = state_ff.data_done || m_data_tready;
      nxt_state.phase_done = state_ff.phase_done || m_phase_tready;
    end
    // Wishbone slave, ack one cycle after the strobe
    nxt_state.ack = wb_cyc_i && wb_stb_i && !state_ff.ack;
    if (wb_cyc_i && wb_stb_i && !state_ff.ack) begin
      case (wb_adr_i)
        REG_CTRL: nxt_state.rdata = ctrl_word;
        REG_STATUS: nxt_state.rdata = stat_word;
        default: nxt_state.rdata = WB_ZERO;
      endcase
    end
    if (wb_cyc_i && wb_stb_i && wb_we_i && state_ff.ack && wb_sel_i[0] &&
        wb_adr_i == REG_CTRL) begin
      nxt_state.run = wb_dat_i[CTRL_RUN_BIT];
      nxt_state.neg_sin = wb_dat_i[CTRL_NEG_SIN_BIT]; // see [R12]
      nxt_state.neg_cos = wb_dat_i[CTRL_NEG_COS_BIT];
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_ff <= RST_STATE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs
  assign s_phase_tready = LUT_ONLY && advance; // see [R7]
  assign m_data_tvalid = last.valid && !state_ff.data_done; // see [R19]
  assign m_phase_tvalid = last.valid && !state_ff.phase_done;
  assign m_phase_tdata = last.phase;
  assign m_data_tdata = (SEL == SEL_BOTH) ? DATA_W'({last.cos, last.sin}) :
    (SEL == SEL_COS) ? DATA_W'(last.cos) : DATA_W'(last.sin); // see [R11]
  assign wb_dat_o = state_ff.rdata;
  assign wb_ack_o = state_ff.ack;

  // Assertions
  localparam bit GEN_START = RUN_RST && !LUT_ONLY;

  sequence s_quiet;
    !m_data_tvalid;
  endsequence

  sequence s_pipe_fill;
    s_quiet ##[PIPE_LAT:PIPE_LAT] m_data_tvalid;
  endsequence

  property p_first_beat;
    @(posedge core_clk) disable iff (!resetn)
    ($rose(resetn) && GEN_START) |-> s_pipe_fill;
  endproperty
  a_first_beat: assert property (p_first_beat) // see [R16]
    else $error("first beat not at pipeline latency");

  property p_chan_wrap;
    @(posedge core_clk) disable iff (!resetn)
    (advance && src_valid && state_ff.chan == CHAN_W'(NUM_CHAN - 1))
      |=> state_ff.chan == '0;
  endproperty
  a_chan_wrap: assert property (p_chan_wrap) // see [R1]
    else $error("channel slot did not wrap");

  property p_chan_hold;
    @(posedge core_clk) disable iff (!resetn)
    !(advance && src_valid) |=> $stable(state_ff.chan);
  endproperty
  a_chan_hold: assert property (p_chan_hold) // see [R1]
    else $error("channel slot moved without a sample");

  property p_data_hold;
    @(posedge core_clk) disable iff (!resetn)
    (m_data_tvalid && !m_data_tready) |=>
      (m_data_tvalid && $stable(m_data_tdata));
  endproperty
  a_data_hold: assert property (p_data_hold) // see [R19]
    else $error("data beat changed before acceptance");

  property p_phase_hold;
    @(posedge core_clk) disable iff (!resetn)
    (m_phase_tvalid && !m_phase_tready) |=>
      (m_phase_tvalid && $stable(m_phase_tdata));
  endproperty
  a_phase_hold: assert property (p_phase_hold) // see [R19]
    else $error("phase beat changed before acceptance");

  property p_raster_range;
    @(posedge core_clk) disable iff (!resetn)
    RASTER |-> (acc_cur < PHASE_W'(MODULUS));
  endproperty
  a_raster_range: assert property (p_raster_range) // see [R20]
    else $error("rasterized phase outside modulus");

  property p_acc_step;
    @(posedge core_clk) disable iff (!resetn)
    (advance && src_valid && !LUT_ONLY && !RASTER) |=>
      state_ff.acc[$past(state_ff.chan)] ==
        PHASE_W'($past(acc_cur) + $past(step_cur));
  endproperty
  a_acc_step: assert property (p_acc_step) // see [R14]
    else $error("accumulator did not take its step");

  property p_no_min;
    @(posedge core_clk) disable iff (!resetn)
    (m_data_tvalid && !USE_SM && SEL != SEL_COS) |->
      m_data_tdata[OUT_W-1:0] != {1'b1, {(OUT_W - 1){1'b0}}};
  endproperty
  a_no_min: assert property (p_no_min) // see [R10]
    else $error("sine field reached the unused negative code");
endmodule // dds_core

// ===== src/dds_pkg.sv
// Function
// [R1] One to sixteen time-multiplexed channels share datapath
// [R2] Standard mode truncates phase to table address
// [R3] Rasterized mode does phase arithmetic modulo modulus
// [R4] Modulus only matters in rasterized mode
// [R5] Rasterized phase width is ceil log2(modulus-1)
// [R6] Phase width sizes accumulator, step, shift, phase
// [R7] Lookup-only mode takes phase from input stream
// [R8] Frequency resolution sets the phase width
// [R9] Truncation, dither or Taylor correction selectable
// [R10] Output width sizes sine and cosine fields
// [R11] Data stream carries sine, cosine or both
// [R12] Optional negation of sine and cosine fields
// [R13] Sign-magnitude only with quadrant symmetry, else twos
// [R14] Per-channel step added each channel sample
// [R15] Per-channel shift added before table lookup
// [R16] Latency automatic from goal or manual count
// [R17] Steps and shifts fixed at build time
// [R18] Phase and output widths are multiples of eight
// [R19] One data and phase beat per slot, held
// [R20] Accumulator wraps at 2^width or at modulus
package dds_pkg;
  localparam int CHAN_MAX = 16;
  localparam int BYTE_W = 8;
  localparam int TBL_AW_DEF = 10;
  localparam int MODULUS_DEF = 200;
  localparam int AUTO_LAT_SPEED = 3;
  localparam int AUTO_LAT_AREA = 1;
  localparam int LAT_MANUAL_DEF = 2;
  localparam int OUT_W_DEF = 16;
  localparam real CLK_MHZ_DEF = 100.0;
  localparam real FREQ_RES_DEF = 10.0;
  localparam real HZ_PER_MHZ = 1.0e6;
  localparam real TWO_PI_REAL = 6.283185307179586;
  localparam int STEP_SHIFT_DEF = 6;
  // Two pi scaled by 2^16 for the Taylor term
  localparam int TWO_PI_FRAC = 16;
  localparam int TWO_PI_W = 20;
  localparam logic [TWO_PI_W-1:0] TWO_PI_Q = 20'h6_487F;
  localparam int LFSR_W = 16;
  localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hB400;
  // Register map, byte addresses, one word each
  localparam int WB_DATA_W = 32;
  localparam int WB_SEL_W = 4;
  localparam int WB_ADR_W = 4;
  localparam logic [WB_ADR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [WB_ADR_W-1:0] REG_STATUS = 4'h4;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_NEG_SIN_BIT = 1;
  localparam int CTRL_NEG_COS_BIT = 2;
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_STALL_BIT = 1;
  localparam int STAT_CHAN_LSB = 8;
  localparam int STAT_CHAN_W = 4;

  typedef enum logic {ACC_STANDARD, ACC_RASTERIZED} dds_accum_t;
  typedef enum logic [1:0] {NS_TRUNC, NS_DITHER, NS_TAYLOR} dds_noise_t;
  typedef enum logic [1:0] {SEL_SIN, SEL_COS, SEL_BOTH} dds_sel_t;
  typedef enum logic {FORM_TWOS, FORM_SIGN_MAG} dds_form_t;
  typedef enum logic {LAT_AUTO, LAT_MANUAL} dds_lat_cfg_t;
  typedef enum logic {GOAL_SPEED, GOAL_AREA} dds_goal_t;

  // Bits for the resolution, rounded up to whole bytes
  function automatic int phase_w_for(real clk_mhz, real res_hz);
    int w;
    w = int'($ceil($ln(clk_mhz * HZ_PER_MHZ / res_hz) / $ln(2.0)));
    return ((w + BYTE_W - 1) / BYTE_W) * BYTE_W; // see [R8] see [R18]
  endfunction
endpackage

// ===== testbench/dds_sink.sv
`timescale 1ns/10ps
module dds_sink (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic stall_en,
  output logic m_data_tready,
  output logic m_phase_tready
);
  integer seed = 56;

  // Both streams ready until the first edge
  initial begin
    m_data_tready = 1'b1;
    m_phase_tready = 1'b1;
  end

  // Each ready line stalls on its own random pattern
  always @(posedge core_clk) begin
    if (!resetn || !stall_en) begin
      m_data_tready <= 1'b1;
      m_phase_tready <= 1'b1;
    end else begin
      m_data_tready <= ($random(seed) % 4) != 0;
      m_phase_tready <= ($random(seed) % 3) != 0;
    end
  end
endmodule // dds_sink

// ===== testbench/tb.sv
`timescale 1ns/10ps
module tb;
  import dds_pkg::*;
  localparam int PW = 24;
  localparam int NCH = 3;
  // Odd step, wrap-at-once step and quarter-turn step
  localparam logic [CHAN_MAX-1:0][PW-1:0] STEPS =
    {{13{24'h00_0000}}, 24'h40_0000, 24'hFF_FFFF, 24'h12_3457};
  logic core_clk, resetn, stall_en;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, pd_d;
  logic m_data_tvalid, m_data_tready, m_phase_tvalid, m_phase_tready;
  logic [31:0] m_data_tdata;
  logic [PW-1:0] m_phase_tdata, pd_p;
  logic pv_d, pr_d, pv_p, pr_p, neg_s, neg_c, have_ref;
  logic [15:0] s1, c0;
  integer seed = 56;
  int err_count = 0;
  int checks = 0;
  int n_dat, n_ph, settle, hold_n;
  // Step above the modulus, a quarter turn once reduced
  localparam logic [PW-1:0] R_STEP = 24'h00_00FA;
  logic r_dv, r_pv;
  logic [15:0] r_dat;
  logic [PW-1:0] r_ph;
  int n_rp, n_rd;

  dds_core #(.NUM_CHAN(NCH), .PER_CHANNEL_STEP(STEPS)) i_dds_core (
    .core_clk(core_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .s_phase_tvalid(1'b0), .s_phase_tready(),
    .s_phase_tdata(24'h00_0000), .m_data_tvalid(m_data_tvalid),
    .m_data_tready(m_data_tready), .m_data_tdata(m_data_tdata),
    .m_phase_tvalid(m_phase_tvalid), .m_phase_tready(m_phase_tready),
    .m_phase_tdata(m_phase_tdata));

  dds_sink i_dds_sink (.core_clk(core_clk), .resetn(resetn),
    .stall_en(stall_en), .m_data_tready(m_data_tready),
    .m_phase_tready(m_phase_tready));

  // Rasterized single channel, sine only, negated from reset
  dds_core #(.ACCUM(ACC_RASTERIZED), .SEL(SEL_SIN), .NEG_SIN(1'b1),
    .PER_CHANNEL_STEP({CHAN_MAX{R_STEP}})) i_dds_core_rast (
    .core_clk(core_clk), .resetn(resetn), .wb_cyc_i(1'b0),
    .wb_stb_i(1'b0), .wb_we_i(1'b0), .wb_adr_i(4'h0), .wb_sel_i(4'h0),
    .wb_dat_i(32'h0000_0000), .wb_dat_o(), .wb_ack_o(),
    .s_phase_tvalid(1'b0), .s_phase_tready(),
    .s_phase_tdata(24'h00_0000), .m_data_tvalid(r_dv),
    .m_data_tready(m_data_tready), .m_data_tdata(r_dat),
    .m_phase_tvalid(r_pv), .m_phase_tready(m_phase_tready),
    .m_phase_tdata(r_ph));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Phase of beat k: channels in turn, n-th sample is n times the step
  function automatic logic [PW-1:0] exp_phase(int k);
    return PW'(k / NCH * STEPS[k % NCH]);
  endfunction

  // Negated sine of rasterized beat n, phases land on quarter turns
  function automatic logic [15:0] exp_rsin(int n);
    case (((n * R_STEP) % MODULUS_DEF) * 4 / MODULUS_DEF)
      1: return 16'h8001;
      3: return 16'h7FFF;
      default: return 16'h0000;
    endcase
  endfunction

  // Quarter-turn channel: zero crossings, symmetry and negation
  task automatic chk_ch2(logic [31:0] d, int n);
    logic [15:0] es, ec;
    if (!have_ref) begin
      if (n == 0) c0 = d[31:16];
      if (n == 1) begin
        s1 = d[15:0];
        have_ref = 1'b1;
        check(32'({s1[15], c0[15]}), 32'h0000_0000);
      end
    end else begin
      case (n % 4)
        0: begin es = '0; ec = c0; end
        1: begin es = s1; ec = '0; end
        2: begin es = '0; ec = -c0; end
        default: begin es = -s1; ec = '0; end
      endcase
      if (neg_s) es = -es;
      if (neg_c) ec = -ec;
      check(d, {ec, es});
    end
  endtask

  // Beat monitor: phase sequence, data fields and hold under stall
  always @(posedge core_clk) begin
    if (!resetn) begin
      n_dat = 0;
      n_ph = 0;
      pv_d = 1'b0;
      pv_p = 1'b0;
    end else begin
      if (pv_d && !pr_d) begin
        check(32'(m_data_tvalid), 32'h0000_0001);
        check(m_data_tdata, pd_d);
      end
      if (pv_p && !pr_p) begin
        check(32'(m_phase_tvalid), 32'h0000_0001);
        check(32'(m_phase_tdata), 32'(pd_p));
      end
      if (m_phase_tvalid && m_phase_tready) begin
        check(32'(m_phase_tdata),
              32'(exp_phase(n_ph)));
        n_ph++;
      end
      if (m_data_tvalid && m_data_tready) begin
        if (settle > 0) settle--;
        else if (n_dat % NCH == 2) chk_ch2(m_data_tdata, n_dat / NCH);
        n_dat++;
      end
      pv_d = m_data_tvalid;
      pr_d = m_data_tready;
      pd_d = m_data_tdata;
      pv_p = m_phase_tvalid;
      pr_p = m_phase_tready;
      pd_p = m_phase_tdata;
    end
  end

  // Rasterized beats: phase wraps at the modulus, negated sine
  always @(posedge core_clk) begin
    if (!resetn) begin
      n_rp = 0;
      n_rd = 0;
    end else begin
      if (r_pv && m_phase_tready) begin
        check(32'(r_ph),
              32'((n_rp * R_STEP) % MODULUS_DEF));
        n_rp++;
      end
      if (r_dv && m_data_tready) begin
        check(32'(r_dat), 32'(exp_rsin(n_rd)));
        n_rd++;
      end
    end
  end

  // Classic single Wishbone cycle, held until ack
  task automatic wb(logic we, logic [3:0] adr, logic [31:0] wd,
                    output logic [31:0] rdat);
    int i;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= wd;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 50);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (i >= 50) begin
      err_count++;
      print_verdict();
    end
  endtask

  task automatic wait_ph(int n);
    int i;
    for (i = 0; i < 3000 && n_ph < n; i++) @(posedge core_clk);
    if (n_ph < n) begin
      err_count++;
      print_verdict();
    end
  endtask

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, stall_en} = 4'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {resetn, neg_s, neg_c, have_ref} = 4'h0;
    settle = 0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    wb(1'b0, REG_CTRL, 32'h0000_0000, rd);
    check(rd, 32'h0000_0001);
    wb(1'b1, 4'hC, $random(seed), rd);
    wb(1'b0, 4'hC, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    wait_ph(40);
    stall_en <= 1'b1;
    wait_ph(90);
    wb(1'b1, REG_CTRL, 32'h0000_0007, rd);
    {neg_s, neg_c} = 2'b11;
    settle = 12;
    wb(1'b0, REG_CTRL, 32'h0000_0000, rd);
    check(rd, 32'h0000_0007);
    wait_ph(150);
    wb(1'b1, REG_CTRL, 32'h0000_0003, rd);
    neg_c = 1'b0;
    settle = 12;
    wait_ph(210);
    // Reset in mid-run: accumulators and negation restart
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    {neg_s, neg_c} = 2'b00;
    settle = 0;
    resetn <= 1'b1;
    wait_ph(60);
    wb(1'b1, REG_CTRL, 32'h0000_0000, rd);
    repeat (20) @(posedge core_clk);
    hold_n = n_ph;
    repeat (20) @(posedge core_clk);
    check(32'(n_ph), 32'(hold_n));
    // Drained and idle: slot count matches beats since reset
    wb(1'b0, REG_STATUS, 32'h0000_0000, rd);
    check(rd, 32'(hold_n % NCH) << STAT_CHAN_LSB);
    print_verdict();
  end
endmodule // tb
